//--- hw/epc_pkg.sv
// Constants and types for the energy pulse calibration control block
package epc_pkg;
  localparam int          CLK_MHZ      = 125;
  localparam real         STEP_NEG_US  = 1.2;
  localparam real         STEP_POS_US  = 2.4;
  localparam real         PER_LSB_US   = 9.6;
  localparam logic [14:0] STEP_NEG_CYC = 15'(int'(STEP_NEG_US * CLK_MHZ));
  localparam logic [14:0] STEP_POS_CYC = 15'(int'(STEP_POS_US * CLK_MHZ));
  localparam logic [10:0] TICK_CYC     = 11'(int'(PER_LSB_US * CLK_MHZ));
  localparam int          PULSE_SHIFT  = 8;
  localparam int          GAIN_SHIFT   = 12;
  localparam int          OS_SHIFT     = 4;
  // Register indices; byte address is four times the index
  localparam logic [6:0]  IDX_ENERGY   = 7'h01;
  localparam logic [6:0]  IDX_PERIOD   = 7'h10;
  localparam logic [6:0]  IDX_OPERATING_MODE_CFG   = 7'h13;
  localparam logic [6:0]  IDX_MEASUREMENT_MODE_CFG    = 7'h14;
  localparam logic [6:0]  IDX_WAVEFORM_MODE_CFG  = 7'h15;
  localparam logic [6:0]  IDX_COMPUTATION_MODE_CFG = 7'h16;
  localparam logic [6:0]  IDX_LCYC     = 7'h17;
  localparam logic [6:0]  IDX_MASK     = 7'h18;
  localparam logic [6:0]  IDX_STATUS   = 7'h19;
  localparam logic [6:0]  IDX_LINECYC  = 7'h1C;
  localparam logic [6:0]  IDX_WGAIN    = 7'h2A;
  localparam logic [6:0]  IDX_WOS      = 7'h39;
  localparam logic [6:0]  IDX_VOS      = 7'h3C;
  localparam logic [6:0]  IDX_PHC      = 7'h3F;
  localparam logic [6:0]  IDX_APNUM    = 7'h45;
  localparam logic [6:0]  IDX_APDEN    = 7'h46;
  localparam logic [6:0]  IDX_RPNUM    = 7'h47;
  localparam logic [6:0]  IDX_RPDEN    = 7'h48;
  // Field positions
  localparam int          OP_PULSE_OFF = 2;
  localparam int          WAV_VA_SEL   = 7;
  localparam int          TERM_LSB     = 2;
  localparam int          LCYC_PERIOD  = 7;
  localparam int          LCYC_ZX_LSB  = 3;
  localparam int          ST_PERIOD    = 9;
  localparam int          ST_LINE_DONE = 12;
  // Values after reset, period limit and response codes
  localparam logic [7:0]  OPERATING_MODE_CFG_RST   = 8'h04;
  localparam logic [7:0]  COMP_RST     = 8'h1C;
  localparam logic [7:0]  LCYC_RST     = 8'h78;
  localparam logic [15:0] LINECYC_RST  = 16'hFFFF;
  localparam logic [11:0] PERIOD_MAX   = 12'hFFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic signed [15:0] watt;
    logic signed [15:0] var_pw;
    logic signed [15:0] va;
  } epc_sample_type;
endpackage

//--- hw/epc_ctrl.sv
// Calibration control: phase delay, power offsets, pulse outputs, line period and line accumulation
// How it works
// - three per-phase delays, asymmetric step weights
// - positive step 1.2 us, negative 2.4 us
// - period register loads only when selected
// - 12-bit period, LSB is 9.6 us
// - term bits 2..4 gate phases into pulses
// - mode bits 1:0 pick period phase
// - watt and var offsets; apparent has none
// - offset LSB is 2^4 below pulse path
// - var offset scaled like watt offset
// - half-cycle accumulation then done interrupt flag
// - operating bit 2 gates both pulses
// - waveform bit 7 picks apparent or reactive
// - 12-bit gain, LSB is 1/4096
`timescale 1ns/1ns
module epc_ctrl (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // AXI4-Lite slave
  input  wire logic [8:0]                    s_axi_awaddr_in,
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire logic [31:0]                   s_axi_wdata_in,
  input  wire logic [3:0]                    s_axi_wstrb_in,
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  output logic [1:0]                         s_axi_bresp_out,
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  input  wire logic [8:0]                    s_axi_araddr_in,
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  output logic [31:0]                        s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out,
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  // Power samples and zero crossings
  input  wire epc_pkg::epc_sample_type [2:0] sample_in,
  input  wire logic                          sample_valid_in,
  input  wire logic [2:0]                    zero_cross_in,
  // Outputs
  output logic                               active_pulse_out,
  output logic                               reactive_pulse_out,
  output logic                               irq_out
);
  logic [2:0]  zx_meta_reg, zx_sync_reg, zx_prev_reg, fire, zx_rise;
  logic [7:0]  operating_mode_cfg_reg, operating_mode_cfg_next, measurement_mode_cfg_reg, measurement_mode_cfg_next, wav_reg, wav_next;
  logic [7:0]  comp_reg, comp_next, lcyc_reg, lcyc_next;
  logic [15:0] linecyc_reg, linecyc_next, mask_reg, mask_next, status_reg, status_next;
  logic [15:0] hcnt_reg, hcnt_next, clr;
  logic [11:0] period_reg, period_next, pcnt_reg, pcnt_next;
  logic [11:0] apnum_reg, apnum_next, apden_reg, apden_next, rpnum_reg, rpnum_next, rpden_reg, rpden_next;
  logic [11:0] wgain_reg [3], wgain_next [3], wos_reg [3], wos_next [3], vos_reg [3], vos_next [3];
  logic [6:0]  phc_reg [3], phc_next [3];
  logic [14:0] dly_reg [3], dly_next [3];
  logic [2:0]  pend_reg, pend_next;
  epc_pkg::epc_sample_type held_reg [3], held_next [3];
  logic [31:0] energy_reg [9], energy_next [9], acc_reg [9], acc_next [9];
  logic [10:0] tick_reg, tick_next;
  logic signed [39:0] apacc_reg, apacc_next, rpacc_reg, rpacc_next, ath, rth;
  logic signed [31:0] asum, rsum, pv [3];
  logic [1:0]  sel;
  logic        apulse_next, rpulse_next, irq_next, tick;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next, wr;
  logic [6:0]  awidx_reg, awidx_next, ridx;
  logic [31:0] wdata_reg, wdata_next, rv, rdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_next, rvalid_next, arready_next;
  logic [1:0]  bresp_next, rresp_next;

  function automatic logic reg_hit(input logic [6:0] i);
    reg_hit = (i >= epc_pkg::IDX_ENERGY && i < epc_pkg::IDX_ENERGY + 7'h09) ||
              (i >= epc_pkg::IDX_PERIOD && i <= epc_pkg::IDX_MASK) ||
              i == epc_pkg::IDX_STATUS || i == epc_pkg::IDX_LINECYC ||
              (i >= epc_pkg::IDX_WGAIN && i < epc_pkg::IDX_WGAIN + 7'h03) ||
              (i >= epc_pkg::IDX_WOS && i <= epc_pkg::IDX_RPDEN);
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // Offset enters four bits below the sample, then gain trims by code/4096
  function automatic logic signed [31:0] pwr(input logic signed [15:0] s, input logic [11:0] os,
                                             input logic [11:0] g);
    logic signed [21:0] p;
    logic signed [33:0] m;
    p = 22'($signed({s, 4'h0})) + 22'($signed(os));
    m = p * $signed(g);
    pwr = 32'(p) + 32'(m >>> epc_pkg::GAIN_SHIFT);
  endfunction

  // Sign chooses the step weight: positive codes fine steps, negative coarse
  function automatic logic [14:0] dly_cyc(input logic [6:0] c);
    logic [6:0] mag;
    mag = c[6] ? 7'(-c) : c;
    dly_cyc = 15'(mag * (c[6] ? epc_pkg::STEP_POS_CYC : epc_pkg::STEP_NEG_CYC));
  endfunction

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zx_meta_reg <= 3'h0;
      zx_sync_reg <= 3'h0;
      zx_prev_reg <= 3'h0;
    end else begin
      zx_meta_reg <= zero_cross_in;
      zx_sync_reg <= zx_meta_reg;
      zx_prev_reg <= zx_sync_reg;
    end
  end

  always_comb begin
    operating_mode_cfg_next = operating_mode_cfg_reg;   measurement_mode_cfg_next = measurement_mode_cfg_reg;     wav_next = wav_reg;
    comp_next = comp_reg;       lcyc_next = lcyc_reg;       linecyc_next = linecyc_reg;
    mask_next = mask_reg;       status_next = status_reg;   period_next = period_reg;
    apnum_next = apnum_reg;     apden_next = apden_reg;     rpnum_next = rpnum_reg;
    rpden_next = rpden_reg;     pend_next = pend_reg;       hcnt_next = hcnt_reg;
    aw_full_next = aw_full_reg; w_full_next = w_full_reg;   awidx_next = awidx_reg;
    wdata_next = wdata_reg;     wstrb_next = wstrb_reg;     bresp_next = s_axi_bresp_out;
    bvalid_next = s_axi_bvalid_out;   rvalid_next = s_axi_rvalid_out;
    rdata_next = s_axi_rdata_out;     rresp_next = s_axi_rresp_out;
    arready_next = s_axi_arready_out;
    for (int i = 0; i < 3; i++) begin
      wgain_next[i] = wgain_reg[i]; wos_next[i] = wos_reg[i]; vos_next[i] = vos_reg[i];
      phc_next[i] = phc_reg[i];     dly_next[i] = dly_reg[i]; held_next[i] = held_reg[i];
    end
    for (int i = 0; i < 9; i++) begin
      energy_next[i] = energy_reg[i];
      acc_next[i] = acc_reg[i];
    end
    // Write channel
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full_next = 1'b1;
      awidx_next = s_axi_awaddr_in[8:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata_in;
      wstrb_next = s_axi_wstrb_in;
    end
    if (s_axi_bvalid_out && s_axi_bready_in) bvalid_next = 1'b0;
    wr = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
    clr = 16'h0000;
    if (wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = reg_hit(awidx_reg) ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
      unique case (awidx_reg)
        epc_pkg::IDX_OPERATING_MODE_CFG:   operating_mode_cfg_next = 8'(wmerge({8'h00, operating_mode_cfg_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_MEASUREMENT_MODE_CFG:    measurement_mode_cfg_next = 8'(wmerge({8'h00, measurement_mode_cfg_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_WAVEFORM_MODE_CFG:  wav_next = 8'(wmerge({8'h00, wav_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_COMPUTATION_MODE_CFG: comp_next = 8'(wmerge({8'h00, comp_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_LCYC:     lcyc_next = 8'(wmerge({8'h00, lcyc_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_MASK:     mask_next = wmerge(mask_reg, wdata_reg, wstrb_reg);
        epc_pkg::IDX_STATUS:   clr = wmerge(16'h0000, wdata_reg, wstrb_reg);
        epc_pkg::IDX_LINECYC:  linecyc_next = wmerge(linecyc_reg, wdata_reg, wstrb_reg);
        epc_pkg::IDX_APNUM:    apnum_next = 12'(wmerge({4'h0, apnum_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_APDEN:    apden_next = 12'(wmerge({4'h0, apden_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_RPNUM:    rpnum_next = 12'(wmerge({4'h0, rpnum_reg}, wdata_reg, wstrb_reg));
        epc_pkg::IDX_RPDEN:    rpden_next = 12'(wmerge({4'h0, rpden_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
      // Per-phase settings change alone; no accumulator is touched
      for (int i = 0; i < 3; i++) begin
        if (awidx_reg == epc_pkg::IDX_WGAIN + 7'(i))
          wgain_next[i] = 12'(wmerge({4'h0, wgain_reg[i]}, wdata_reg, wstrb_reg));
        if (awidx_reg == epc_pkg::IDX_WOS + 7'(i))
          wos_next[i] = 12'(wmerge({4'h0, wos_reg[i]}, wdata_reg, wstrb_reg));
        if (awidx_reg == epc_pkg::IDX_VOS + 7'(i))
          vos_next[i] = 12'(wmerge({4'h0, vos_reg[i]}, wdata_reg, wstrb_reg));
        if (awidx_reg == epc_pkg::IDX_PHC + 7'(i))
          phc_next[i] = 7'(wmerge({9'h000, phc_reg[i]}, wdata_reg, wstrb_reg));
      end
    end
    status_next = status_reg & ~clr;
    // Read channel
    ridx = s_axi_araddr_in[8:2];
    rv = 32'h0000_0000;
    unique case (ridx)
      epc_pkg::IDX_PERIOD:   rv = {20'h00000, period_reg};
      epc_pkg::IDX_OPERATING_MODE_CFG:   rv = {24'h000000, operating_mode_cfg_reg};
      epc_pkg::IDX_MEASUREMENT_MODE_CFG:    rv = {24'h000000, measurement_mode_cfg_reg};
      epc_pkg::IDX_WAVEFORM_MODE_CFG:  rv = {24'h000000, wav_reg};
      epc_pkg::IDX_COMPUTATION_MODE_CFG: rv = {24'h000000, comp_reg};
      epc_pkg::IDX_LCYC:     rv = {24'h000000, lcyc_reg};
      epc_pkg::IDX_MASK:     rv = {16'h0000, mask_reg};
      epc_pkg::IDX_STATUS:   rv = {16'h0000, status_reg};
      epc_pkg::IDX_LINECYC:  rv = {16'h0000, linecyc_reg};
      epc_pkg::IDX_APNUM:    rv = {20'h00000, apnum_reg};
      epc_pkg::IDX_APDEN:    rv = {20'h00000, apden_reg};
      epc_pkg::IDX_RPNUM:    rv = {20'h00000, rpnum_reg};
      epc_pkg::IDX_RPDEN:    rv = {20'h00000, rpden_reg};
      default: ;
    endcase
    for (int i = 0; i < 9; i++)
      if (ridx == epc_pkg::IDX_ENERGY + 7'(i)) rv = energy_reg[i];
    for (int i = 0; i < 3; i++) begin
      if (ridx == epc_pkg::IDX_WGAIN + 7'(i)) rv = {20'h00000, wgain_reg[i]};
      if (ridx == epc_pkg::IDX_WOS + 7'(i)) rv = {20'h00000, wos_reg[i]};
      if (ridx == epc_pkg::IDX_VOS + 7'(i)) rv = {20'h00000, vos_reg[i]};
      if (ridx == epc_pkg::IDX_PHC + 7'(i)) rv = {25'h0000000, phc_reg[i]};
    end
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_next = 1'b1;
      arready_next = 1'b0;
      rdata_next = rv;
      rresp_next = reg_hit(ridx) ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
    end
    // Line period in 9.6 us ticks on the selected phase
    tick = (tick_reg == epc_pkg::TICK_CYC - 11'h001);
    tick_next = tick ? 11'h000 : tick_reg + 11'h001;
    sel = (measurement_mode_cfg_reg[1:0] == 2'h3) ? 2'h2 : measurement_mode_cfg_reg[1:0];
    zx_rise = zx_sync_reg & ~zx_prev_reg;
    pcnt_next = (tick && pcnt_reg != epc_pkg::PERIOD_MAX) ? pcnt_reg + 12'h001 : pcnt_reg;
    if (zx_rise[sel]) begin
      pcnt_next = 12'h000;
      if (lcyc_reg[epc_pkg::LCYC_PERIOD]) begin
        period_next = pcnt_reg;
        status_next[epc_pkg::ST_PERIOD] = 1'b1;
      end
    end
    // Delayed sample release, then energy and pulse sums
    asum = 32'sh0;
    rsum = 32'sh0;
    for (int i = 0; i < 3; i++) begin
      fire[i] = pend_reg[i] && dly_reg[i] == 15'h0000;
      if (pend_reg[i] && dly_reg[i] != 15'h0000) dly_next[i] = dly_reg[i] - 15'h0001;
      if (fire[i]) pend_next[i] = 1'b0;
      if (sample_valid_in) begin
        held_next[i] = sample_in[i];
        dly_next[i] = dly_cyc(phc_reg[i]);
        pend_next[i] = 1'b1;
      end
      pv[0] = pwr(held_reg[i].watt, wos_reg[i], wgain_reg[i]);
      pv[1] = pwr(held_reg[i].var_pw, vos_reg[i], 12'h000);
      pv[2] = pwr(held_reg[i].va, 12'h000, 12'h000);
      if (fire[i]) begin
        for (int k = 0; k < 3; k++)
          if (lcyc_reg[k]) acc_next[k*3+i] = acc_reg[k*3+i] + pv[k];
          else energy_next[k*3+i] = energy_reg[k*3+i] + pv[k];
        if (comp_reg[epc_pkg::TERM_LSB+i]) begin
          asum = asum + pv[0];
          rsum = rsum + (wav_reg[epc_pkg::WAV_VA_SEL] ? pv[2] : pv[1]);
        end
      end
    end
    // Zero numerator counts as one, so a cleared numerator gives the plain divisor
    ath = 40'(apden_reg == 12'h000 ? 13'h1 : {1'b0, apden_reg}) <<< epc_pkg::PULSE_SHIFT;
    rth = 40'(rpden_reg == 12'h000 ? 13'h1 : {1'b0, rpden_reg}) <<< epc_pkg::PULSE_SHIFT;
    apacc_next = apacc_reg + 40'(asum * $signed({1'b0, apnum_reg == 12'h000 ? 12'h001 : apnum_reg}));
    rpacc_next = rpacc_reg + 40'(rsum * $signed({1'b0, rpnum_reg == 12'h000 ? 12'h001 : rpnum_reg}));
    apulse_next = 1'b0;
    rpulse_next = 1'b0;
    if (apacc_next >= ath) begin
      apacc_next = apacc_next - ath;
      apulse_next = !operating_mode_cfg_reg[epc_pkg::OP_PULSE_OFF];
    end
    if (rpacc_next >= rth) begin
      rpacc_next = rpacc_next - rth;
      rpulse_next = !operating_mode_cfg_reg[epc_pkg::OP_PULSE_OFF];
    end
    // Half line cycles: every enabled phase edge counts one
    if (|lcyc_reg[2:0]) begin
      hcnt_next = hcnt_reg +
        16'($countones((zx_sync_reg ^ zx_prev_reg) & lcyc_reg[epc_pkg::LCYC_ZX_LSB +: 3]));
      if (hcnt_next >= linecyc_reg) begin
        hcnt_next = 16'h0000;
        status_next[epc_pkg::ST_LINE_DONE] = 1'b1;
        for (int i = 0; i < 9; i++)
          if (lcyc_reg[i/3]) begin
            energy_next[i] = acc_next[i];
            acc_next[i] = 32'h0000_0000;
          end
      end
    end else begin
      hcnt_next = 16'h0000;
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      operating_mode_cfg_reg <= epc_pkg::OPERATING_MODE_CFG_RST;   measurement_mode_cfg_reg <= 8'h00;    wav_reg <= 8'h00;
      comp_reg <= epc_pkg::COMP_RST;       lcyc_reg <= epc_pkg::LCYC_RST;
      linecyc_reg <= epc_pkg::LINECYC_RST; mask_reg <= 16'h0000;  status_reg <= 16'h0000;
      period_reg <= 12'h000;  pcnt_reg <= 12'h000;  tick_reg <= 11'h000;  hcnt_reg <= 16'h0000;
      apnum_reg <= 12'h000;   apden_reg <= 12'h000; rpnum_reg <= 12'h000; rpden_reg <= 12'h000;
      pend_reg <= 3'h0;       apacc_reg <= 40'sh0;  rpacc_reg <= 40'sh0;
      aw_full_reg <= 1'b0;    w_full_reg <= 1'b0;   awidx_reg <= 7'h00;
      wdata_reg <= 32'h0000_0000;  wstrb_reg <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        wgain_reg[i] <= 12'h000; wos_reg[i] <= 12'h000; vos_reg[i] <= 12'h000;
        phc_reg[i] <= 7'h00;     dly_reg[i] <= 15'h0000; held_reg[i] <= '0;
      end
      for (int i = 0; i < 9; i++) begin
        energy_reg[i] <= 32'h0000_0000;
        acc_reg[i] <= 32'h0000_0000;
      end
      s_axi_awready_out <= 1'b1;  s_axi_wready_out <= 1'b1;  s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'h0;    s_axi_arready_out <= 1'b1; s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;  s_axi_rresp_out <= 2'h0;
      active_pulse_out <= 1'b0;   reactive_pulse_out <= 1'b0; irq_out <= 1'b0;
    end else begin
      operating_mode_cfg_reg <= operating_mode_cfg_next;   measurement_mode_cfg_reg <= measurement_mode_cfg_next;  wav_reg <= wav_next;
      comp_reg <= comp_next;       lcyc_reg <= lcyc_next;    linecyc_reg <= linecyc_next;
      mask_reg <= mask_next;       status_reg <= status_next; period_reg <= period_next;
      pcnt_reg <= pcnt_next;       tick_reg <= tick_next;    hcnt_reg <= hcnt_next;
      apnum_reg <= apnum_next;     apden_reg <= apden_next;  rpnum_reg <= rpnum_next;
      rpden_reg <= rpden_next;     pend_reg <= pend_next;    apacc_reg <= apacc_next;
      rpacc_reg <= rpacc_next;     aw_full_reg <= aw_full_next; w_full_reg <= w_full_next;
      awidx_reg <= awidx_next;     wdata_reg <= wdata_next;  wstrb_reg <= wstrb_next;
      for (int i = 0; i < 3; i++) begin
        wgain_reg[i] <= wgain_next[i]; wos_reg[i] <= wos_next[i]; vos_reg[i] <= vos_next[i];
        phc_reg[i] <= phc_next[i];     dly_reg[i] <= dly_next[i]; held_reg[i] <= held_next[i];
      end
      for (int i = 0; i < 9; i++) begin
        energy_reg[i] <= energy_next[i];
        acc_reg[i] <= acc_next[i];
      end
      s_axi_awready_out <= !aw_full_next; s_axi_wready_out <= !w_full_next;
      s_axi_bvalid_out <= bvalid_next;    s_axi_bresp_out <= bresp_next;
      s_axi_arready_out <= arready_next;  s_axi_rvalid_out <= rvalid_next;
      s_axi_rdata_out <= rdata_next;      s_axi_rresp_out <= rresp_next;
      active_pulse_out <= apulse_next;    reactive_pulse_out <= rpulse_next;
      irq_out <= irq_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_arm_fine; sample_valid_in && phc_reg[0] == 7'h01; endsequence
  sequence s_arm_coarse; sample_valid_in && phc_reg[0] == 7'h7F; endsequence
  property p_pulse_off; operating_mode_cfg_reg[2] |=> !active_pulse_out && !reactive_pulse_out; endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse while gated");
  property p_step_fine; s_arm_fine |=> dly_reg[0] == 15'h0096; endproperty
  a_step_fine: assert property (p_step_fine) else $error("fine step not 150 cycles");
  property p_step_coarse; s_arm_coarse |=> dly_reg[0] == 15'h012C; endproperty
  a_step_coarse: assert property (p_step_coarse) else $error("coarse step not 300 cycles");
  property p_count_down;
    pend_reg[0] && dly_reg[0] != 15'h0000 && !sample_valid_in |=>
      dly_reg[0] == $past(dly_reg[0]) - 15'h0001 && pend_reg[0];
  endproperty
  a_count_down: assert property (p_count_down) else $error("delay did not count");
  property p_period_hold; !lcyc_reg[7] |=> $stable(period_reg); endproperty
  a_period_hold: assert property (p_period_hold) else $error("period moved unselected");
  property p_period_load; zx_rise[sel] && lcyc_reg[7] |=> period_reg == $past(pcnt_reg) && pcnt_reg == 12'h0; endproperty
  a_period_load: assert property (p_period_load) else $error("period not loaded");
  property p_term_gate;
    (fire & comp_reg[4:2]) == 3'h0 && apacc_reg < ath |=> $stable(apacc_reg) && !active_pulse_out;
  endproperty
  a_term_gate: assert property (p_term_gate) else $error("gated phase reached pulse");
  property p_sticky;
    status_reg[12] && !(wr && awidx_reg == epc_pkg::IDX_STATUS && wdata_reg[12] && wstrb_reg[1]) |=>
      status_reg[12];
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");
  property p_irq; status_reg[12] && mask_reg[12] |-> irq_out; endproperty
  a_irq: assert property (p_irq) else $error("masked-in flag without interrupt");
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule

//--- dv/tb_epc_ctrl.sv
// Self-checking testbench for the energy pulse calibration control block
`timescale 1ns/1ns
module tb_epc_ctrl;
  logic                        clk_in = 0, rst_in = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sv = 0;
  logic [8:0]                  aw = 0, ar = 0;
  logic [31:0]                 wd = 0;
  logic [2:0]                  zx = 0;
  logic [15:0]                 w;
  epc_pkg::epc_sample_type [2:0] smp = '0;
  wire                         awr, wrr, bv, arr, rv, ap, rp, irq;
  wire [1:0]                   rresp, bresp;
  wire [31:0]                  rdat;
  logic [33:0]                 exp_q[$];
  int                          n_fail = 0, cmp_count = 0, seed = 32'ha036ef37;
  initial forever #4 clk_in = ~clk_in;
  epc_ctrl u_dut (.clk_in, .rst_in, .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rr), .sample_in(smp), .sample_valid_in(sv), .zero_cross_in(zx),
    .active_pulse_out(ap), .reactive_pulse_out(rp), .irq_out(irq));
  task automatic chk(input logic [33:0] got, input logic [33:0] e);
    cmp_count++;
    if (got !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // Read answers are compared in arrival order against the queued notes
  always @(posedge clk_in) if (rv && rr) chk({rresp, rdat}, exp_q.pop_front());
  // Waits are unbounded; only the watchdog ends a hang
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    aw <= {a, 2'h0}; wd <= d; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'h0;
      if (wrr) wv <= 1'h0;
    end while (!bv);
    chk({32'h0, bresp}, {32'h0, epc_pkg::RESP_OKAY});
    br <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [6:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    ar <= {a, 2'h0}; arv <= 1'h1; rr <= 1'h1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rr <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic fire(input logic [15:0] v);
    smp[0].watt <= v; smp[0].va <= v; sv <= 1'h1;
    @(posedge clk_in);
    sv <= 1'h0;
  endtask
  // Expects {reactive, active}: silent for q cycles, then seen within 40
  task automatic waitp(input logic [1:0] e, input int q);
    logic [1:0] s = 2'h0;
    fire(16'h0100);
    repeat (q) begin @(posedge clk_in); s = s | {rp, ap}; end
    if (q > 0) chk({32'h0, s}, 34'h0);
    s = 2'h0;
    repeat (40) begin @(posedge clk_in); s = s | {rp, ap}; end
    chk({32'h0, s}, {32'h0, e});
  endtask
  task summarize;
    $display("counts: compares=%0d mismatches=%0d pending=%0d", cmp_count, n_fail, exp_q.size());
    if (n_fail == 0 && cmp_count > 0 && exp_q.size() == 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin #200000; n_fail++; summarize; end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'h0;
    @(posedge clk_in);
    rd(epc_pkg::IDX_COMPUTATION_MODE_CFG, {26'h0, epc_pkg::COMP_RST});
    rd(7'h7F, {epc_pkg::RESP_SLVERR, 32'h0});
    wr(epc_pkg::IDX_PERIOD, 32'hABC); rd(epc_pkg::IDX_PERIOD, 34'h0);
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      wr(epc_pkg::IDX_MEASUREMENT_MODE_CFG, {24'h0, w[7:2], 2'(i)}); rd(epc_pkg::IDX_MEASUREMENT_MODE_CFG, {26'h0, w[7:2], 2'(i)});
    end
    wr(epc_pkg::IDX_WOS, 32'hFFD); rd(epc_pkg::IDX_WOS, 34'hFFD);
    $display("register test done");
    w = 16'($random(seed)) & 16'h03FF;
    wr(epc_pkg::IDX_MASK, 32'h1000); wr(epc_pkg::IDX_LINECYC, 32'h2); wr(epc_pkg::IDX_LCYC, 32'h9);
    fire(w);
    repeat (10) @(posedge clk_in);
    zx <= 3'h1; repeat (10) @(posedge clk_in);
    zx <= 3'h0; repeat (10) @(posedge clk_in);
    chk({33'h0, irq}, 34'h1);
    rd(epc_pkg::IDX_ENERGY, {2'h0, 32'(w) * 32'h10 - 32'h3});
    rd(epc_pkg::IDX_STATUS, {2'h0, 32'h1000}); wr(epc_pkg::IDX_STATUS, 32'h1000);
    chk({33'h0, irq}, 34'h0);
    $display("line accumulation test done");
    wr(epc_pkg::IDX_COMPUTATION_MODE_CFG, 32'h4); wr(epc_pkg::IDX_APNUM, 32'h0); wr(epc_pkg::IDX_APDEN, 32'h1);
    wr(epc_pkg::IDX_OPERATING_MODE_CFG, 32'h0); waitp(2'h1, 0);
    wr(epc_pkg::IDX_COMPUTATION_MODE_CFG, 32'h8); waitp(2'h0, 0);
    wr(epc_pkg::IDX_COMPUTATION_MODE_CFG, 32'h4); wr(epc_pkg::IDX_WAVEFORM_MODE_CFG, 32'h80); waitp(2'h3, 0);
    wr(epc_pkg::IDX_OPERATING_MODE_CFG, 32'h4); waitp(2'h0, 0);
    $display("pulse test done");
    wr(epc_pkg::IDX_OPERATING_MODE_CFG, 32'h0); wr(epc_pkg::IDX_PHC, 32'h01); waitp(2'h3, 140);
    wr(epc_pkg::IDX_PHC, 32'h7F); waitp(2'h3, 290);
    $display("delay test done");
    wr(epc_pkg::IDX_MEASUREMENT_MODE_CFG, 32'h1); wr(epc_pkg::IDX_LCYC, 32'h80);
    zx <= 3'h2; @(posedge clk_in); zx <= 3'h0;
    // Rising edges 2401 cycles apart hold exactly two 1200-cycle ticks
    repeat (2 * epc_pkg::TICK_CYC) @(posedge clk_in);
    zx <= 3'h2; repeat (10) @(posedge clk_in);
    rd(epc_pkg::IDX_PERIOD, 34'h2); rd(epc_pkg::IDX_STATUS, {2'h0, 32'h0200});
    $display("period test done");
    summarize;
  end
endmodule
